/* File: rtl/dskif_pkg.sv */
package dskif_pkg;
   // Clock rate and derived counts
   localparam int CLK_MHZ          = 125;
   localparam int CLK_PERIOD_PS    = 8000;
   localparam int STEP_MIN_NS      = 1000;
   localparam int STEP_CYC         = (STEP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int DIR_SETUP_NS     = 1000;
   localparam int DIR_CYC          = (DIR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WGATE_LEAD_NS    = 8000;
   localparam int WGATE_CYC        = (WGATE_LEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WPULSE_NS        = 250;
   localparam int WPULSE_CYC       = (WPULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PRECOMP_NS       = 125;
   localparam int PRECOMP_CYC      = (PRECOMP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RECAL_MAX_STEPS  = 77;
   localparam int CNT_W            = 11;
   localparam int STEP_W           = 8;

   typedef enum logic [1:0] {
      DSKIF_PC_NONE,
      DSKIF_PC_EARLY,
      DSKIF_PC_LATE
   } dskif_pc_t;

   typedef enum logic [1:0] {
      DSKIF_OP_STEP,
      DSKIF_OP_RECAL,
      DSKIF_OP_SEEK
   } dskif_op_t;
endpackage : dskif_pkg

/* File: rtl/dskif_step_if.sv */
`timescale 1ns/1ps
// Step request path between sequencer and step pulse generator
interface dskif_step_if;
   logic req;
   logic dir;
   logic busy;
   logic done;
   modport ctl (output req, output dir, input busy, input done);
   modport gen (input req, input dir, output busy, output done);
endinterface : dskif_step_if

/* File: rtl/dskif_step_gen.sv */
`timescale 1ns/1ps
module dskif_step_gen
   import dskif_pkg::*;
(
   input  wire logic       clock,  // System clock
   input  wire logic       rst_n,  // Async reset
   dskif_step_if.gen       stp,    // Step request
   output logic            step,   // Head-move pulse, active high
   output logic            dir     // Travel direction, high = inward
);
   typedef enum logic [1:0] {SG_IDLE, SG_SETUP, SG_PULSE, SG_HOLD} dskif_sg_t;
   typedef struct packed {
      dskif_sg_t          st;
      logic [CNT_W-1:0]   cnt;
      logic               step;
      logic               dir;
      logic               done;
   } dskif_sgs_t;

   dskif_sgs_t s, next_s;

   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      case (s.st)
         SG_IDLE: begin
            if (stp.req) begin
               next_s.dir = stp.dir;
               next_s.cnt = CNT_W'(DIR_CYC - 1);
               next_s.st  = SG_SETUP;
            end
         end
         SG_SETUP: begin
            if (s.cnt == '0) begin
               next_s.step = 1'b1;
               next_s.cnt  = CNT_W'(STEP_CYC - 1);
               next_s.st   = SG_PULSE;
            end else begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         SG_PULSE: begin
            if (s.cnt == '0) begin
               next_s.step = 1'b0;
               next_s.cnt  = CNT_W'(DIR_CYC - 1);
               next_s.st   = SG_HOLD;
            end else begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         SG_HOLD: begin
            if (s.cnt == '0) begin
               next_s.done = 1'b1;
               next_s.st   = SG_IDLE;
            end else begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         default: next_s.st = SG_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign step     = s.step;
   assign dir      = s.dir;
   assign stp.busy = (s.st != SG_IDLE);
   assign stp.done = s.done;
endmodule : dskif_step_gen

/* File: rtl/dskif_wr_gen.sv */
`timescale 1ns/1ps
module dskif_wr_gen
   import dskif_pkg::*;
(
   input  wire logic       clock,   // System clock
   input  wire logic       rst_n,   // Async reset
   input  wire logic       bit_req, // One-cycle request to write a 1
   input  dskif_pc_t       pc,      // Precompensation choice
   output logic            wpulse   // Write pulse, active high
);
   typedef struct packed {
      logic [5:0] dly;
      logic       dly_run;
      logic [5:0] wid;
      logic       wpulse;
   } dskif_wgs_t;

   dskif_wgs_t s, next_s;

   // Nominal delay sits at one precomp step, so early and late both fit
   // Wide enough for two precomp steps; a narrower count wraps to zero
   function automatic logic [5:0] pc_delay(input dskif_pc_t p);
      case (p)
         DSKIF_PC_EARLY: pc_delay = 6'd0;
         DSKIF_PC_LATE:  pc_delay = 6'(2 * PRECOMP_CYC);
         default:        pc_delay = 6'(PRECOMP_CYC);
      endcase
   endfunction : pc_delay

   always_comb begin
      next_s = s;
      if (bit_req && !s.dly_run && !s.wpulse) begin
         next_s.dly     = pc_delay(pc);
         next_s.dly_run = 1'b1;
      end else if (s.dly_run) begin
         if (s.dly == '0) begin
            next_s.dly_run = 1'b0;
            next_s.wpulse  = 1'b1;
            next_s.wid     = 6'(WPULSE_CYC - 1);
         end else begin
            next_s.dly = s.dly - 1'b1;
         end
      end else if (s.wpulse) begin
         if (s.wid == '0) begin
            next_s.wpulse = 1'b0;
         end else begin
            next_s.wid = s.wid - 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign wpulse = s.wpulse;
endmodule : dskif_wr_gen

/* File: rtl/dskif_top.sv */
`timescale 1ns/1ps
module dskif_top
   import dskif_pkg::*;
#(
   parameter int RECAL_STEPS = RECAL_MAX_STEPS
) (
   input  wire logic             clock,        // 125 MHz system clock
   input  wire logic             rst_n,        // Async reset, active low
   input  wire logic             unit,         // Target drive number
   input  wire logic [1:0]       motor_on,     // Spindle request per drive
   input  wire logic             hd_mode,      // High-density request
   input  wire logic             head_sel,     // Head number request
   input  wire logic             cmd_valid,    // One-cycle command strobe
   input  dskif_pkg::dskif_op_t  cmd_op,       // Command code
   input  wire logic             cmd_dir,      // Direction for single step and seek
   input  wire logic [STEP_W-1:0] cmd_count,   // Step count for seek
   input  wire logic             wr_start,     // Begin write operation
   input  wire logic             wr_stop,      // End write operation
   input  wire logic             wr_bit,       // One-cycle write-a-1 strobe
   input  dskif_pkg::dskif_pc_t  wr_pc,        // Precompensation choice
   input  wire logic             index_pin,    // Index from drive, active high
   input  wire logic             trk0_pin,     // Track zero, active high
   input  wire logic             wprot_pin,    // Write protect, active high
   input  wire logic             rdata_pin,    // Read pulse, active high
   input  wire logic             dchg_pin,     // Media change, active high
   output logic [1:0]            drv_sel,      // Drive select lines
   output logic [1:0]            motor,        // Spindle-run lines
   output logic                  hd_sel,       // Density-choice line
   output logic                  step,         // Head-move line
   output logic                  dir,          // Travel-direction line
   output logic                  head1,        // Head-choice line
   output logic                  wgate,        // Write-gate line
   output logic                  wdata,        // Write-pulse line
   output logic                  busy,         // Command in progress
   output logic                  cmd_done,     // Command finished pulse
   output logic                  equip_chk,    // Recalibrate failed
   output logic                  drv_absent,   // Drive not detected
   output logic                  wr_ready,     // Lead time elapsed
   output logic                  wr_prot,      // Synced write protect
   output logic                  trk0,         // Synced track zero
   output logic                  media_chg,    // Synced media change
   output logic                  index_evt,    // Index leading edge pulse
   output logic                  rd_pulse      // Read pulse leading edge
);
   typedef enum logic [1:0] {ST_IDLE, ST_STEP, ST_WAIT} dskif_st_t;
   typedef struct packed {
      logic [4:0]          s1;
      logic [4:0]          s2;
      logic                idx_d;
      logic                rd_d;
      dskif_st_t           st;
      dskif_op_t           op;
      logic [STEP_W-1:0]   left;
      logic                sdir;
      logic                req;
      logic [1:0]          drv_sel;
      logic [1:0]          motor;
      logic                hd_sel;
      logic                head1;
      logic                wgate;
      logic [CNT_W-1:0]    wcnt;
      logic                wr_ready;
      logic                busy;
      logic                cmd_done;
      logic                equip_chk;
      logic                drv_absent;
      logic                index_evt;
      logic                rd_pulse;
      logic                step;
      logic                dir;
      logic                wdata;
   } dskif_ts_t;

   dskif_ts_t   s, next_s;
   dskif_step_if stp();
   logic        g_step;
   logic        g_dir;
   logic        g_wdata;
   logic        wr_fire;

   dskif_step_gen u_step (
      .clock (clock),
      .rst_n (rst_n),
      .stp   (stp),
      .step  (g_step),
      .dir   (g_dir)
   );

   // Data only reaches the drive once the gate lead has passed
   assign wr_fire = wr_bit & s.wr_ready & s.wgate;

   dskif_wr_gen u_wr (
      .clock   (clock),
      .rst_n   (rst_n),
      .bit_req (wr_fire),
      .pc      (wr_pc),
      .wpulse  (g_wdata)
   );

   assign stp.req = s.req;
   assign stp.dir = s.sdir;

   // Pin bits: index, track zero, protect, read, change
   always_comb begin
      next_s          = s;
      next_s.s1       = {index_pin, trk0_pin, wprot_pin, rdata_pin, dchg_pin};
      next_s.s2       = s.s1;
      next_s.idx_d    = s.s2[4];
      next_s.rd_d     = s.s2[1];
      next_s.req      = 1'b0;
      next_s.cmd_done = 1'b0;
      next_s.step     = g_step;
      next_s.dir      = g_dir;
      next_s.wdata    = g_wdata;
      next_s.index_evt = s.s2[4] & ~s.idx_d;
      next_s.rd_pulse  = s.s2[1] & ~s.rd_d;

      next_s.drv_sel = unit ? 2'b10 : 2'b01;
      next_s.motor   = motor_on;
      next_s.hd_sel  = hd_mode;
      next_s.head1   = head_sel;

      // Gate lead time counter; protected media never gated
      if (wr_stop || s.s2[2]) begin
         next_s.wgate    = 1'b0;
         next_s.wr_ready = 1'b0;
      end else if (wr_start && !s.wgate) begin
         next_s.wgate    = 1'b1;
         next_s.wcnt     = CNT_W'(WGATE_CYC - 1);
         next_s.wr_ready = 1'b0;
      end else if (s.wgate && !s.wr_ready) begin
         if (s.wcnt == '0) begin
            next_s.wr_ready = 1'b1;
         end else begin
            next_s.wcnt = s.wcnt - 1'b1;
         end
      end

      case (s.st)
         ST_IDLE: begin
            if (cmd_valid && !s.wgate) begin
               next_s.busy = 1'b1;
               next_s.op   = cmd_op;
               case (cmd_op)
                  DSKIF_OP_RECAL: begin
                     next_s.equip_chk = 1'b0;
                     next_s.left      = STEP_W'(RECAL_STEPS);
                     next_s.sdir      = 1'b0;
                  end
                  DSKIF_OP_SEEK: begin
                     next_s.left = cmd_count;
                     next_s.sdir = cmd_dir;
                  end
                  default: begin
                     next_s.left = STEP_W'(1);
                     next_s.sdir = cmd_dir;
                  end
               endcase
               next_s.st = ST_STEP;
            end
         end
         ST_STEP: begin
            if (s.op == DSKIF_OP_RECAL && s.s2[3]) begin
               next_s.drv_absent = 1'b0;
               next_s.busy       = 1'b0;
               next_s.cmd_done   = 1'b1;
               next_s.st         = ST_IDLE;
            end else if (s.left == '0) begin
               if (s.op == DSKIF_OP_RECAL) begin
                  // No track zero after full sweep
                  next_s.equip_chk  = 1'b1;
                  next_s.drv_absent = 1'b1;
               end
               next_s.busy     = 1'b0;
               next_s.cmd_done = 1'b1;
               next_s.st       = ST_IDLE;
            end else if (!stp.busy) begin
               // Each step lets the drive clear change
               next_s.req  = 1'b1;
               next_s.left = s.left - 1'b1;
               next_s.st   = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (stp.done) begin
               next_s.st = ST_STEP;
            end
         end
         default: next_s.st = ST_IDLE;
      endcase
   end

   // All drive lines idle under reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign drv_sel    = s.drv_sel;
   assign motor      = s.motor;
   assign hd_sel     = s.hd_sel;
   assign step       = s.step;
   assign dir        = s.dir;
   assign head1      = s.head1;
   assign wgate      = s.wgate;
   assign wdata      = s.wdata;
   assign busy       = s.busy;
   assign cmd_done   = s.cmd_done;
   assign equip_chk  = s.equip_chk;
   assign drv_absent = s.drv_absent;
   assign wr_ready   = s.wr_ready;
   assign wr_prot    = s.s2[2];
   assign trk0       = s.s2[3];
   assign media_chg  = s.s2[0];
   assign index_evt  = s.index_evt;
   assign rd_pulse   = s.rd_pulse;
endmodule : dskif_top

/* File: test/dskif_sva.sv */
`timescale 1ns/1ps
module dskif_sva
   import dskif_pkg::*;
(
   input wire logic       clock,     // Clock
   input wire logic       rst_n,     // Reset
   input wire logic [1:0] motor_on,  // Spindle req
   input wire logic       hd_mode,   // Density req
   input wire logic       head_sel,  // Head req
   input wire logic       trk0,      // Track zero
   input wire logic [1:0] drv_sel,   // Selects
   input wire logic [1:0] motor,     // Spindles
   input wire logic       hd_sel,    // Density
   input wire logic       head1,     // Head
   input wire logic       step,      // Head move
   input wire logic       dir,       // Direction
   input wire logic       wgate,     // Write gate
   input wire logic       wdata,     // Write pulse
   input wire logic       equip_chk  // Recal failed
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [10:0] step_len;
   logic [10:0] wd_len;
   logic [10:0] gate_len;
   // Gate length saturates, a write may run for long
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         step_len <= 11'h000;
         wd_len   <= 11'h000;
         gate_len <= 11'h000;
      end else begin
         step_len <= step ? step_len + 11'h001 : 11'h000;
         wd_len   <= wdata ? wd_len + 11'h001 : 11'h000;
         gate_len <= !wgate ? 11'h000 : (&gate_len ? gate_len : gate_len + 11'h001);
      end
   end
   sequence step_end_s; $fell(step); endsequence
   sequence dir_hold_s; $stable(dir) [*8]; endsequence
   step_width_a: assert property (step_end_s |-> step_len == 11'd125)
      else $error("head-move pulse width wrong");
   dir_stable_a: assert property (step |-> $stable(dir))
      else $error("direction moved during pulse");
   dir_hold_a: assert property (step_end_s |-> dir_hold_s)
      else $error("direction moved after pulse");
   levels_follow_a: assert property ($past(rst_n) |-> {motor, hd_sel, head1} ==
      {$past(motor_on), $past(hd_mode), $past(head_sel)})
      else $error("level outputs do not follow");
   select_first_a: assert property ((step || wgate) |-> $onehot(drv_sel) && $stable(drv_sel))
      else $error("drive operated unselected");
   gate_lead_a: assert property ($rose(wdata) |-> gate_len >= 11'd1000)
      else $error("write pulse too soon after gate");
   wpulse_width_a: assert property ($fell(wdata) |-> wd_len == 11'd32)
      else $error("write pulse width wrong");
   equip_cause_a: assert property ($rose(equip_chk) |-> !trk0)
      else $error("equipment check with track zero");
endmodule : dskif_sva

bind dskif_top dskif_sva i_dskif_sva (.clock, .rst_n, .motor_on, .hd_mode, .head_sel, .trk0,
   .drv_sel, .motor, .hd_sel, .head1, .step, .dir, .wgate, .wdata, .equip_chk);

/* File: test/dskif_drive_model.sv */
`timescale 1ns/1ps
module dskif_drive_model #(
   parameter int IDX_CYC = 125,  // Index width, scaled
   parameter int REV_CYC = 1600  // Turn length, scaled
) (
   input  wire logic clock,    // Clock
   input  wire logic sel,      // Select
   input  wire logic run,      // Spindle
   input  wire logic step,     // Head move
   input  wire logic dir,      // Direction
   input  wire logic wgate,    // Write gate
   input  wire logic wdata,    // Write pulse
   input  wire logic present,  // Medium in
   input  wire logic prot,     // Window open
   output logic      index_o,  // Index
   output logic      trk0_o,   // Track zero
   output logic      wprot_o,  // Protect
   output logic      rdata_o,  // Read pulse
   output logic      dchg_o,   // Change
   output int        track,    // Head track
   output int        writes    // Ones written
);
   int   rot    = 0;
   logic step_q = 1'b0;
   logic wd_q   = 1'b0;
   logic chg    = 1'b1;
   wire  on     = sel && present;
   initial track = 5;
   initial writes = 0;
   always @(posedge clock) begin
      step_q <= step;
      wd_q <= wdata;
      if (run && present)
         rot <= (rot + 1) % REV_CYC;
      if (sel && step_q && !step) begin
         track <= dir ? track + 1 : (track > 0 ? track - 1 : 0);
         chg <= !present;
      end
      if (sel && wgate && !prot && wdata && !wd_q)
         writes <= writes + 1;
   end
   assign index_o = on && run && rot < IDX_CYC;
   assign trk0_o  = on && track == 0;
   assign wprot_o = on && prot;
   assign rdata_o = on && run && rot >= 500 && rot % 500 < 32;
   assign dchg_o  = sel && chg;
endmodule : dskif_drive_model

/* File: test/test_dskif_top.sv */
`timescale 1ns/1ps
module test_dskif_top;
   import dskif_pkg::*;
   logic clock = 1'b0, rst_n = 1'b0, unit = 1'b0, hd_mode = 1'b0, head_sel = 1'b0;
   logic cmd_valid = 1'b0, cmd_dir = 1'b0, wr_start = 1'b0, wr_stop = 1'b0, wr_bit = 1'b0;
   logic [1:0] motor_on = 2'b00, prot = 2'b00, drv_sel, motor;
   wire  [1:0] idx, tz, wp, rd, dc;
   logic [STEP_W-1:0] cmd_count = 8'h00;
   dskif_op_t cmd_op = DSKIF_OP_STEP;
   dskif_pc_t wr_pc = DSKIF_PC_NONE;
   logic hd_sel, step, dir, head1, wgate, wdata, busy, cmd_done, equip_chk, drv_absent;
   logic wr_ready, wr_prot, trk0, media_chg, index_evt, rd_pulse;
   int trk_a, trk_b, wr_a, wr_b;
   int bad_count = 0, comparisons = 0, cycles = 0;

   dskif_top #(.RECAL_STEPS(3)) i_dskif_top (.clock, .rst_n, .unit, .motor_on, .hd_mode,
      .head_sel, .cmd_valid, .cmd_op, .cmd_dir, .cmd_count, .wr_start, .wr_stop, .wr_bit,
      .wr_pc, .index_pin(|idx), .trk0_pin(|tz), .wprot_pin(|wp), .rdata_pin(|rd),
      .dchg_pin(|dc), .drv_sel, .motor, .hd_sel, .step, .dir, .head1, .wgate, .wdata, .busy,
      .cmd_done, .equip_chk, .drv_absent, .wr_ready, .wr_prot, .trk0, .media_chg,
      .index_evt, .rd_pulse);
   dskif_drive_model i_dskif_drive_model_0 (.clock, .sel(drv_sel[0]), .run(motor[0]), .step,
      .dir, .wgate, .wdata, .present(1'b1), .prot(prot[0]), .index_o(idx[0]), .trk0_o(tz[0]),
      .wprot_o(wp[0]), .rdata_o(rd[0]), .dchg_o(dc[0]), .track(trk_a), .writes(wr_a));
   dskif_drive_model i_dskif_drive_model_1 (.clock, .sel(drv_sel[1]), .run(motor[1]), .step,
      .dir, .wgate, .wdata, .present(1'b0), .prot(prot[1]), .index_o(idx[1]), .trk0_o(tz[1]),
      .wprot_o(wp[1]), .rdata_o(rd[1]), .dchg_o(dc[1]), .track(trk_b), .writes(wr_b));

   initial forever #4 clock = ~clock;

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude

   // Whole run needs about 10000 cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         bad_count++;
         conclude();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t %s", $time, what);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask : tick

   task automatic run_cmd(input dskif_op_t op, input logic d, input logic [7:0] n,
                          input logic dup);
      int w;
      cmd_op = op;
      cmd_dir = d;
      cmd_count = n;
      cmd_valid = 1'b1;
      tick(1);
      cmd_valid = 1'b0;
      if (dup) begin
         tick(5);
         check(busy, 1, "busy missing");
         cmd_valid = 1'b1;
         tick(1);
         cmd_valid = 1'b0;
      end
      w = 0;
      while (cmd_done !== 1'b1 && w < 4000) begin
         tick(1);
         w++;
      end
      check(w < 4000, 1, "command hung");
      tick(3);
   endtask : run_cmd

   task automatic t_levels();
      {unit, motor_on, hd_mode, head_sel} = 5'h17;
      tick(2);
      check({drv_sel, motor, hd_sel, head1}, 6'h27, "levels high");
      // Spindle of drive 0 keeps turning for the index scenario
      {unit, motor_on, hd_mode, head_sel} = 5'h0c;
      tick(4);
      check({drv_sel, motor, hd_sel, head1}, 6'h1c, "levels low");
      check(media_chg, 1, "change at power-on");
   endtask : t_levels

   task automatic t_step();
      run_cmd(DSKIF_OP_STEP, 1'b1, 8'h00, 1'b1);
      check(trk_a, 6, "inward step");
      check(busy, 0, "busy strobe taken");
      run_cmd(DSKIF_OP_SEEK, 1'b0, 8'h03, 1'b0);
      check(trk_a, 3, "outward seek");
      run_cmd(DSKIF_OP_SEEK, 1'b1, 8'h00, 1'b0);
      check(trk_a, 3, "empty seek");
      check(media_chg, 0, "change not cleared");
   endtask : t_step

   task automatic t_recal();
      run_cmd(DSKIF_OP_RECAL, 1'b0, 8'h00, 1'b0);
      check({trk_a[7:0], trk0, equip_chk, drv_absent}, 11'h004, "recal found");
      unit = 1'b1;
      tick(2);
      run_cmd(DSKIF_OP_RECAL, 1'b0, 8'h00, 1'b0);
      check({trk_b[7:0], equip_chk, drv_absent}, 10'h00b, "absent drive");
      unit = 1'b0;
      tick(2);
   endtask : t_recal

   task automatic t_write();
      int n;
      int d [3];
      wr_start = 1'b1;
      tick(1);
      wr_start = 1'b0;
      n = 0;
      while (wr_ready !== 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      check(n >= 999 && n < 1010, 1, "gate lead");
      for (int p = 0; p < 3; p++) begin
         wr_pc = dskif_pc_t'(p);
         wr_bit = 1'b1;
         tick(1);
         wr_bit = 1'b0;
         n = 0;
         while (wdata !== 1'b1 && n < 100) begin
            tick(1);
            n++;
         end
         d[p] = n;
         n = 0;
         while (wdata === 1'b1 && n < 100) begin
            tick(1);
            n++;
         end
         check(n, 32, "write pulse width");
         tick(500);
      end
      check(d[0] - d[1], 16, "early shift");
      check(d[2] - d[0], 16, "late shift");
      check(wr_a, 3, "ones written");
      wr_stop = 1'b1;
      tick(1);
      wr_stop = 1'b0;
      tick(2);
      check(wgate, 0, "gate not dropped");
   endtask : t_write

   task automatic t_prot();
      prot = 2'b01;
      tick(4);
      check(wr_prot, 1, "protect seen");
      wr_start = 1'b1;
      tick(1);
      wr_start = 1'b0;
      tick(3);
      check(wgate, 0, "gate on protected");
      prot = 2'b00;
   endtask : t_prot

   task automatic t_index();
      int ni;
      int nr;
      ni = 0;
      nr = 0;
      for (int i = 0; i < 3200; i++) begin
         tick(1);
         ni += (index_evt === 1'b1);
         nr += (rd_pulse === 1'b1);
      end
      check(ni, 2, "index per turn");
      check(nr, 6, "read pulses");
   endtask : t_index

   initial begin
      motor_on = 2'b11;
      hd_mode = 1'b1;
      tick(3);
      check({drv_sel, motor, hd_sel, step, dir, head1, wgate, wdata}, 0, "reset idle");
      rst_n = 1'b1;
      t_levels();
      t_step();
      t_recal();
      t_write();
      t_prot();
      t_index();
      conclude();
   end
endmodule : test_dskif_top
